// ==== battery_week_alarm_timer.sv ====
// battery week alarm timer: divider, week counter, sub-week counter,
// four interrupt sources, power-up request and ten general outputs
// assumes an Avalon-MM master on sys_clk; nrst is the battery-well reset
//
// Functional notes
// - week and sub-week alarms raise power-up request
// - drive ten battery general outputs
// - registers reachable only over controller bus
// - counting independent of standby-well bus side
// - register access handled in bus clock domain
// - counting logic advances on 32 kHz tick
// - battery reset clears every register and counter
// - system reset only blocks bus access
// - week interrupt while count at least compare
// - sub-week interrupt on step from one to zero, or to reload when repeating
// - one-second interrupt once per divider wrap
// - fractional-second interrupt at selected rate
// - all interrupts driven unmasked when enabled
// - week and sub-week alarms usable as wake without bus access
// - 28-bit week counter increments each second
// - 9-bit sub-week down-counter, one-shot or repeating
// - 15-bit divider, one-hertz tick on wrap
// - request suppressed and dropped when wake enable clear
`timescale 1ns/1ns
module battery_week_alarm_timer (
    input wire logic sys_clk, // system clock, 125 MHz
    input wire logic nrst, // battery-well reset, async
    input wire logic system_bus_reset, // standby-well reset, high
    input wire logic [7:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte lanes
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall
    output logic week_alarm_int, // level
    output logic sub_week_alarm_int, // pulse
    output logic one_second_int, // pulse
    output logic sub_second_int, // pulse
    output logic power_up_request, // wake request level
    output logic [9:0] battery_general_outputs // general outputs
);
    // address match, used by both decode paths
    function automatic logic at(input logic [7:0] a, input logic [7:0] ofs);
        at = (a[7:2] == ofs[7:2]);
    endfunction

    // byte-lane merge of write data into an old word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
        input logic [3:0] be);
        merge = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
                merge[i*8 +: 8] = wd[i*8 +: 8];
        end
    endfunction

    week_timer_pkg::bus_state_t bus_state, next_bus_state;
    logic next_waitrequest;
    logic [31:0] next_readdata;
    logic [11:0] tick_cnt, next_tick_cnt;
    logic block_enable, next_block_enable;
    logic wake_output_enable, next_wake_output_enable;
    logic [27:0] week_count, next_week_count;
    logic [27:0] week_compare, next_week_compare;
    logic [14:0] divider, next_divider;
    logic [2:0] tick_select, next_tick_select;
    logic sub_repeat, next_sub_repeat;
    logic [8:0] sub_count, next_sub_count;
    logic [8:0] sub_reload, next_sub_reload;
    logic [3:0] fraction_rate_select, next_fraction_rate_select;
    logic [9:0] next_general_outputs;
    logic next_week_int, next_sub_week_int, next_one_second, next_sub_second, next_power_up;
    logic slow_tick, accept_write, sub_tick, sub_fire, week_hit;
    logic [3:0] week_bit;
    logic [31:0] w_ctrl, w_week, w_cmp, w_div, w_subctl, w_sub, w_rate, w_gpo;

    // bus handshake: one stall cycle, then a single answer cycle
    always_comb
    begin
        next_bus_state = bus_state;
        next_waitrequest = 1'b1;
        next_readdata = avs_readdata;
        case (bus_state)
            week_timer_pkg::BUS_IDLE:
            begin
                if ((avs_read || avs_write) && !system_bus_reset)
                begin
                    next_bus_state = week_timer_pkg::BUS_ANSWER;
                    next_waitrequest = 1'b0;
                    next_readdata = week_timer_pkg::RESET_WORD;
                    if (avs_read)
                    begin
                        if (at(avs_address, week_timer_pkg::OFS_CONTROL))
                            next_readdata[1:0] = {wake_output_enable, block_enable};
                        else if (at(avs_address, week_timer_pkg::OFS_WEEK_COUNT))
                            next_readdata[27:0] = week_count;
                        else if (at(avs_address, week_timer_pkg::OFS_WEEK_COMPARE))
                            next_readdata[27:0] = week_compare;
                        else if (at(avs_address, week_timer_pkg::OFS_DIVIDER))
                            next_readdata[14:0] = divider;
                        else if (at(avs_address, week_timer_pkg::OFS_SUB_CONTROL))
                            next_readdata[3:0] = {sub_repeat, tick_select};
                        else if (at(avs_address, week_timer_pkg::OFS_SUB_COUNT))
                            next_readdata[8:0] = sub_count;
                        else if (at(avs_address, week_timer_pkg::OFS_FRACTION_RATE))
                            next_readdata[3:0] = fraction_rate_select;
                        else if (at(avs_address, week_timer_pkg::OFS_GENERAL_OUTPUTS))
                            next_readdata[9:0] = battery_general_outputs;
                        else if (at(avs_address, week_timer_pkg::OFS_STATUS))
                            next_readdata[1:0] = {power_up_request, week_alarm_int};
                    end
                end
            end
            week_timer_pkg::BUS_ANSWER:
                next_bus_state = week_timer_pkg::BUS_IDLE; // master releases here
            default:
                next_bus_state = week_timer_pkg::BUS_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bus_state <= week_timer_pkg::BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata <= week_timer_pkg::RESET_WORD;
        end
        else
        begin
            bus_state <= next_bus_state;
            avs_waitrequest <= next_waitrequest;
            avs_readdata <= next_readdata;
        end
    end

    // timekeeping and settings; system_bus_reset never reaches this group
    always_comb
    begin
        // free-running 32 kHz enable, battery clock is always present
        slow_tick = (tick_cnt == week_timer_pkg::SLOW_TICK_LAST);
        next_tick_cnt = slow_tick ? 12'h000 : tick_cnt + 12'h001;
        // a write lands on the edge where waitrequest is seen low
        accept_write = !avs_waitrequest && avs_write;
        w_ctrl = merge({30'h0, wake_output_enable, block_enable}, avs_writedata, avs_byteenable);
        w_week = merge({4'h0, week_count}, avs_writedata, avs_byteenable);
        w_cmp = merge({4'h0, week_compare}, avs_writedata, avs_byteenable);
        w_div = merge({17'h0, divider}, avs_writedata, avs_byteenable);
        w_subctl = merge({28'h0, sub_repeat, tick_select}, avs_writedata, avs_byteenable);
        w_sub = merge({23'h0, sub_count}, avs_writedata, avs_byteenable);
        w_rate = merge({28'h0, fraction_rate_select}, avs_writedata, avs_byteenable);
        w_gpo = merge({22'h0, battery_general_outputs}, avs_writedata, avs_byteenable);
        next_block_enable = block_enable;
        next_wake_output_enable = wake_output_enable;
        next_week_compare = week_compare;
        next_tick_select = tick_select;
        next_sub_repeat = sub_repeat;
        next_sub_reload = sub_reload;
        next_fraction_rate_select = fraction_rate_select;
        next_general_outputs = battery_general_outputs;
        next_divider = divider;
        next_week_count = week_count;
        next_sub_count = sub_count;
        next_one_second = 1'b0;
        next_sub_second = 1'b0;
        sub_fire = 1'b0;
        // divider and week counter hold while disabled
        if (block_enable && slow_tick)
        begin
            next_divider = divider + 15'h0001;
            if (divider == week_timer_pkg::DIV_MAX)
            begin
                next_one_second = 1'b1;
                next_week_count = week_count + 28'h0000001;
            end
            // fraction rate n gives 2^n Hz: low 15-n bits back at zero
            if (fraction_rate_select != 4'h0)
                next_sub_second = ((next_divider & (week_timer_pkg::DIV_MAX >> fraction_rate_select))
                    == 15'h0000);
        end
        // week bit 3, 5, 7 or 9 rising is the slow sub-week source
        week_bit = {1'b0, tick_select[1:0], 1'b1} + 4'h2;
        case (tick_select)
            week_timer_pkg::TICK_OFF: sub_tick = 1'b0;
            week_timer_pkg::TICK_SUB_SECOND: sub_tick = next_sub_second;
            week_timer_pkg::TICK_SECOND: sub_tick = next_one_second;
            week_timer_pkg::TICK_RESERVED: sub_tick = 1'b0;
            default: sub_tick = next_one_second && !week_count[week_bit] && next_week_count[week_bit];
        endcase
        if (sub_tick && sub_count != 9'h000)
        begin
            if (sub_count == 9'h001)
            begin
                sub_fire = 1'b1;
                next_sub_count = sub_repeat ? sub_reload : 9'h000;
            end
            else
                next_sub_count = sub_count - 9'h001;
        end
        // software writes win over counting in the same cycle
        if (accept_write)
        begin
            if (at(avs_address, week_timer_pkg::OFS_CONTROL))
            begin
                next_block_enable = w_ctrl[week_timer_pkg::CTRL_ENABLE_BIT];
                next_wake_output_enable = w_ctrl[week_timer_pkg::CTRL_WAKE_EN_BIT];
            end
            if (at(avs_address, week_timer_pkg::OFS_WEEK_COUNT))
                next_week_count = w_week[27:0];
            if (at(avs_address, week_timer_pkg::OFS_WEEK_COMPARE))
                next_week_compare = w_cmp[27:0];
            if (at(avs_address, week_timer_pkg::OFS_DIVIDER))
                next_divider = w_div[14:0];
            if (at(avs_address, week_timer_pkg::OFS_SUB_CONTROL))
            begin
                next_tick_select = w_subctl[2:0];
                next_sub_repeat = w_subctl[week_timer_pkg::SUBCTL_REPEAT_BIT];
            end
            if (at(avs_address, week_timer_pkg::OFS_SUB_COUNT))
            begin
                next_sub_count = w_sub[8:0];
                next_sub_reload = w_sub[8:0];
            end
            if (at(avs_address, week_timer_pkg::OFS_FRACTION_RATE))
                next_fraction_rate_select = w_rate[3:0];
            if (at(avs_address, week_timer_pkg::OFS_GENERAL_OUTPUTS))
                next_general_outputs = w_gpo[9:0];
        end
        // interrupts go out unmasked; the aggregator does the masking
        week_hit = block_enable && (week_count >= week_compare);
        next_week_int = next_block_enable && (next_week_count >= next_week_compare);
        next_sub_week_int = sub_fire;
        // request holds until software clears the wake enable
        next_power_up = next_wake_output_enable && (power_up_request || week_hit || sub_fire);
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tick_cnt <= 12'h000;
            block_enable <= 1'b0;
            wake_output_enable <= 1'b0;
            week_count <= 28'h0000000;
            week_compare <= 28'h0000000;
            divider <= 15'h0000;
            tick_select <= 3'h0;
            sub_repeat <= 1'b0;
            sub_count <= 9'h000;
            sub_reload <= 9'h000;
            fraction_rate_select <= 4'h0;
            battery_general_outputs <= 10'h000;
            week_alarm_int <= 1'b0;
            sub_week_alarm_int <= 1'b0;
            one_second_int <= 1'b0;
            sub_second_int <= 1'b0;
            power_up_request <= 1'b0;
        end
        else
        begin
            tick_cnt <= next_tick_cnt;
            block_enable <= next_block_enable;
            wake_output_enable <= next_wake_output_enable;
            week_count <= next_week_count;
            week_compare <= next_week_compare;
            divider <= next_divider;
            tick_select <= next_tick_select;
            sub_repeat <= next_sub_repeat;
            sub_count <= next_sub_count;
            sub_reload <= next_sub_reload;
            fraction_rate_select <= next_fraction_rate_select;
            battery_general_outputs <= next_general_outputs;
            week_alarm_int <= next_week_int;
            sub_week_alarm_int <= next_sub_week_int;
            one_second_int <= next_one_second;
            sub_second_int <= next_sub_second;
            power_up_request <= next_power_up;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    sequence s_req_pending;
        (avs_read || avs_write) && avs_waitrequest && bus_state == week_timer_pkg::BUS_IDLE
            && !system_bus_reset;
    endsequence
    sequence s_single_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    chk_bus_one_stall: assert property (s_req_pending |=> s_single_answer)
        else $error("bus answer not after one stall cycle");
    chk_sysreset_blocks: assert property (system_bus_reset && avs_waitrequest |=> avs_waitrequest)
        else $error("bus answered during system reset");
    chk_week_level: assert property (block_enable && week_count >= week_compare |-> week_alarm_int)
        else $error("week interrupt missing while count reaches compare");
    chk_sub_fire: assert property (sub_week_alarm_int |-> $past(sub_count) == 9'h001)
        else $error("sub-week interrupt without step from one");
    chk_second_wrap: assert property (one_second_int |-> divider == 15'h0000 && $past(divider) == 15'h7FFF)
        else $error("one-second pulse not at divider wrap");
    chk_rate_zero: assert property (sub_second_int |-> $past(fraction_rate_select) != 4'h0 && $past(block_enable))
        else $error("fraction interrupt with rate zero or disabled");
    chk_hold_disabled: assert property (!block_enable && !accept_write |=> $stable(divider) && $stable(week_count))
        else $error("counters moved while disabled");
    chk_wake_clear: assert property (!wake_output_enable |-> !power_up_request)
        else $error("power-up request with wake enable clear");
    chk_wake_alarm: assert property (wake_output_enable && week_hit ##1 wake_output_enable
        |-> power_up_request)
        else $error("week alarm did not raise power-up request");
    chk_gpo_write: assert property (accept_write && at(avs_address, week_timer_pkg::OFS_GENERAL_OUTPUTS)
        && avs_byteenable == 4'hF |=> battery_general_outputs == $past(avs_writedata[9:0]))
        else $error("general outputs did not take written value");
endmodule

// ==== tb_battery_week_alarm_timer.sv ====
// self-checking bench for the battery week alarm timer
// assumes one 125 MHz clock; the 32 kHz rate is an internal enable
`timescale 1ns/1ns
module tb_battery_week_alarm_timer;
    localparam int T = week_timer_pkg::SLOW_TICK_CYCLES;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic system_bus_reset = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, week_alarm_int, sub_week_alarm_int, one_second_int, sub_second_int;
    logic power_up_request, wake_out;
    logic [9:0] battery_general_outputs;
    logic [3:0] int_pending;
    logic [31:0] q, q2;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    int n;

    always #4 sys_clk = ~sys_clk;

    battery_week_alarm_timer dut (.sys_clk(sys_clk), .nrst(nrst), .system_bus_reset(system_bus_reset),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .week_alarm_int(week_alarm_int), .sub_week_alarm_int(sub_week_alarm_int),
        .one_second_int(one_second_int), .sub_second_int(sub_second_int),
        .power_up_request(power_up_request), .battery_general_outputs(battery_general_outputs));

    wake_partner partner (.sys_clk(sys_clk), .nrst(nrst), .power_up_request(power_up_request),
        .int_lines({sub_second_int, one_second_int, sub_week_alarm_int, week_alarm_int}),
        .int_mask(4'hF), .wake_out(wake_out), .int_pending(int_pending));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
        output logic [31:0] rd);
        int k;
        k = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        do
        begin
            @(posedge sys_clk);
            k++;
        end
        while (avs_waitrequest !== 1'b0 && k < 1000);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        check("bus answer", avs_waitrequest, 1'b0);
    endtask

    // bounded wait for a level at an edge; k is -1 when it never came
    task automatic wait_for(input int which, input int max, output int k);
        logic s;
        k = 0;
        s = 1'b0;
        while (s !== 1'b1 && k < max)
        begin
            @(posedge sys_clk);
            k++;
            case (which)
                0: s = one_second_int;
                1: s = sub_week_alarm_int;
                2: s = sub_second_int;
                3: s = week_alarm_int;
                4: s = power_up_request;
                5: s = !week_alarm_int;
                default: s = !power_up_request;
            endcase
        end
        if (s !== 1'b1)
            k = -1;
    endtask

    task automatic test_defaults;
        bus(0, week_timer_pkg::OFS_CONTROL, 0, 4'hF, q);
        check("control", q, 32'h0);
        bus(0, week_timer_pkg::OFS_WEEK_COUNT, 0, 4'hF, q);
        check("week count", q, 32'h0);
        bus(0, week_timer_pkg::OFS_STATUS, 0, 4'hF, q);
        check("status", q, 32'h0);
        bus(0, 8'h40, 0, 4'hF, q);
        check("unmapped read", q, 32'h0);
        check("outputs", battery_general_outputs, 10'h000);
        $display("test defaults done");
    endtask

    task automatic test_outputs;
        bus(1, week_timer_pkg::OFS_GENERAL_OUTPUTS, 32'hFFFF_FFFF, 4'hF, q);
        // the write lands on the edge the task returns at; look one edge later
        @(posedge sys_clk);
        check("outputs all", battery_general_outputs, 10'h3FF);
        bus(1, week_timer_pkg::OFS_GENERAL_OUTPUTS, 32'h0, 4'h1, q);
        bus(0, week_timer_pkg::OFS_GENERAL_OUTPUTS, 0, 4'hF, q);
        check("outputs lane", q, 32'h300);
        check("outputs pins", battery_general_outputs, 10'h300);
        $display("test outputs done");
    endtask

    // two wraps bring the week count to the compare value
    task automatic test_week;
        bus(1, week_timer_pkg::OFS_WEEK_COMPARE, 32'h2, 4'hF, q);
        bus(1, week_timer_pkg::OFS_DIVIDER, 32'h7FFE, 4'hF, q);
        bus(1, week_timer_pkg::OFS_CONTROL, 32'h3, 4'hF, q);
        wait_for(0, 3 * T, n);
        check("second pulse", n > 0, 1'b1);
        bus(0, week_timer_pkg::OFS_WEEK_COUNT, 0, 4'hF, q);
        check("week count one", q, 32'h1);
        check("below compare", week_alarm_int, 1'b0);
        check("no request", power_up_request, 1'b0);
        check("pending second", int_pending[2], 1'b1);
        bus(1, week_timer_pkg::OFS_DIVIDER, 32'h7FFE, 4'hF, q);
        wait_for(0, 3 * T, n);
        wait_for(3, T + 10, n);
        check("week alarm", n > 0, 1'b1);
        wait_for(4, T + 10, n);
        check("request", n > 0, 1'b1);
        check("wake out", wake_out, 1'b1);
        bus(0, week_timer_pkg::OFS_STATUS, 0, 4'hF, q);
        check("status set", q, 32'h3);
        bus(1, week_timer_pkg::OFS_CONTROL, 32'h1, 4'hF, q);
        wait_for(6, T + 10, n);
        check("request dropped", n > 0, 1'b1);
        check("wake dropped", wake_out, 1'b0);
        check("alarm unmasked", week_alarm_int, 1'b1);
        bus(1, week_timer_pkg::OFS_WEEK_COMPARE, 32'h3, 4'hF, q);
        wait_for(5, T + 10, n);
        check("alarm clears", n > 0, 1'b1);
        $display("test week done");
    endtask

    task automatic test_sub_week;
        bus(1, week_timer_pkg::OFS_FRACTION_RATE, 32'hF, 4'hF, q);
        bus(1, week_timer_pkg::OFS_SUB_CONTROL, 32'h1, 4'hF, q);
        bus(1, week_timer_pkg::OFS_SUB_COUNT, 32'h2, 4'hF, q);
        wait_for(2, T + 10, n);
        check("fraction pulse", n > 0, 1'b1);
        wait_for(1, 3 * T, n);
        check("sub alarm", n > 0, 1'b1);
        wait_for(1, 4 * T, n);
        check("one shot", n, -1);
        bus(1, week_timer_pkg::OFS_SUB_CONTROL, 32'h9, 4'hF, q);
        bus(1, week_timer_pkg::OFS_SUB_COUNT, 32'h2, 4'hF, q);
        wait_for(1, 3 * T, n);
        wait_for(1, 3 * T, n);
        check("repeat alarm", n > 0, 1'b1);
        // week bit 3 source: count 7 to 8 raises bit 3; stop sub counter before touching week count
        bus(1, week_timer_pkg::OFS_SUB_COUNT, 32'h0, 4'hF, q);
        bus(1, week_timer_pkg::OFS_WEEK_COUNT, 32'h7, 4'hF, q);
        bus(1, week_timer_pkg::OFS_SUB_CONTROL, 32'h4, 4'hF, q);
        bus(1, week_timer_pkg::OFS_DIVIDER, 32'h7FFE, 4'hF, q);
        bus(1, week_timer_pkg::OFS_SUB_COUNT, 32'h1, 4'hF, q);
        wait_for(1, 3 * T, n);
        check("week bit tick", n > 0, 1'b1);
        $display("test sub week done");
    endtask

    // bus stalls under system reset while the settings survive
    task automatic test_bus_reset;
        int lows;
        lows = 0;
        @(posedge sys_clk);
        system_bus_reset <= 1'b1;
        fork
            bus(0, week_timer_pkg::OFS_CONTROL, 0, 4'hF, q);
            begin
                repeat (20)
                begin
                    @(posedge sys_clk);
                    lows += (avs_waitrequest === 1'b0);
                end
                system_bus_reset <= 1'b0;
            end
        join
        check("stalled", lows, 0);
        check("control kept", q, 32'h1);
        $display("test bus reset done");
    endtask

    task automatic test_disable;
        bus(1, week_timer_pkg::OFS_CONTROL, 32'h0, 4'hF, q);
        bus(0, week_timer_pkg::OFS_DIVIDER, 0, 4'hF, q);
        wait_for(2, 2 * T, n);
        check("no pulse", n, -1);
        bus(0, week_timer_pkg::OFS_DIVIDER, 0, 4'hF, q2);
        check("divider held", q2, q);
        $display("test disable done");
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // hang guard, well above the expected run of about 69k cycles
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 95000)
        begin
            mismatches++;
            give_verdict();
        end
    end

    initial
    begin
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        test_defaults();
        test_outputs();
        test_week();
        test_sub_week();
        test_bus_reset();
        test_disable();
        give_verdict();
    end
endmodule

// ==== wake_partner.sv ====
// far-side stand-in: wake control interface plus interrupt aggregator
// assumes the timer outputs are on sys_clk and sampled at rising edges
`timescale 1ns/1ns
module wake_partner (
    input wire logic sys_clk, // system clock
    input wire logic nrst, // battery-well reset
    input wire logic power_up_request, // request from the timer
    input wire logic [3:0] int_lines, // timer interrupt sources
    input wire logic [3:0] int_mask, // aggregator enables
    output logic wake_out, // external wake output
    output logic [3:0] int_pending // sticky, masked here only
);
    // wake follows the request with no delay of its own
    assign wake_out = power_up_request;
    // masking belongs to the aggregator, never to the timer
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            int_pending <= 4'h0;
        else
            int_pending <= int_pending | (int_lines & int_mask);
    end
endmodule

// ==== week_timer_pkg.sv ====
// constants, offsets and types for the battery week alarm timer
// assumes a single 125 MHz system clock; slower rates are enable pulses
package week_timer_pkg;
    // clocking: the 32.768 kHz count rate is an enable pulse
    localparam int unsigned SYS_CLK_HZ = 125000000;
    localparam int unsigned SLOW_CLK_HZ = 32768;
    localparam int unsigned SLOW_TICK_CYCLES = SYS_CLK_HZ / SLOW_CLK_HZ;
    localparam logic [11:0] SLOW_TICK_LAST = 12'(SLOW_TICK_CYCLES - 1);

    // counter widths
    localparam int WEEK_W = 28;
    localparam int SUB_W = 9;
    localparam int DIV_W = 15;
    localparam int GPO_W = 10;
    localparam logic [14:0] DIV_MAX = 15'h7FFF;

    // register byte offsets
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_WEEK_COUNT = 8'h04;
    localparam logic [7:0] OFS_WEEK_COMPARE = 8'h08;
    localparam logic [7:0] OFS_DIVIDER = 8'h0C;
    localparam logic [7:0] OFS_SUB_CONTROL = 8'h10;
    localparam logic [7:0] OFS_SUB_COUNT = 8'h14;
    localparam logic [7:0] OFS_FRACTION_RATE = 8'h18;
    localparam logic [7:0] OFS_GENERAL_OUTPUTS = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;

    // field positions
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_WAKE_EN_BIT = 1;
    localparam int SUBCTL_REPEAT_BIT = 3;
    localparam int STAT_WEEK_BIT = 0;
    localparam int STAT_WAKE_BIT = 1;

    // sub-week tick source codes
    localparam logic [2:0] TICK_OFF = 3'h0;
    localparam logic [2:0] TICK_SUB_SECOND = 3'h1;
    localparam logic [2:0] TICK_SECOND = 3'h2;
    localparam logic [2:0] TICK_RESERVED = 3'h3;

    // reset values
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ANSWER = 2'b10
    } bus_state_t;
endpackage
